// File: verilog/dor_pkg.sv
// Shared constants and types of the descriptor outer-reload engine
package dor_pkg;
	// APB register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_DESCRIPTOR_POINTER = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	// Address bit that selects the descriptor/data memory window
	localparam int MEM_SEL_BIT = 8;
	localparam int MEM_AW      = 5;
	// Control register bits
	localparam int CTRL_TRIG = 0;
	// Status register bits
	localparam int STAT_BUSY    = 0;
	localparam int STAT_DONE    = 1;
	localparam int STAT_OPENERR = 2;
	localparam int STAT_REFUSED = 3;
	localparam int STAT_REBUILD = 4;
	// Control word fields
	localparam int DV_LO   = 0;
	localparam int ST_LO   = 2;
	localparam int MODE_B  = 4;
	localparam int ORL_LO  = 5;
	localparam int SAC_LO  = 8;
	localparam int DAC_LO  = 11;
	// Count word fields
	localparam int IRM_LO  = 0;
	localparam int IIN_LO  = 8;
	localparam int ORM_LO  = 16;
	// Descriptor word indices
	localparam logic [2:0] W_CTRL   = 3'h0;
	localparam logic [2:0] W_CNT    = 3'h1;
	localparam logic [2:0] W_SRC    = 3'h2;
	localparam logic [2:0] W_DST    = 3'h3;
	localparam logic [2:0] W_BACKUP = 3'h4;
	localparam logic [2:0] MAND_WORDS = 3'h4;
	localparam int MAX_WORDS = 7;
	// State field codes
	localparam logic [1:0] ST_FRESH   = 2'h0;
	localparam logic [1:0] ST_RUN     = 2'h1;
	localparam logic [1:0] ST_CLEAN   = 2'h2;
	localparam logic [1:0] ST_REBUILD = 2'h3;
	// Remaining counts left behind when the counter is not reloaded
	localparam logic [15:0] ORM_END = 16'h0001;
	localparam logic [7:0]  IRM_END = 8'h01;
	// Reset values
	localparam logic [MEM_AW-1:0] RST_DESCRIPTOR_POINTER = 5'h00;

	typedef enum logic [2:0] {
		DOR_IDLE = 3'h0,
		DOR_RD   = 3'h1,
		DOR_RDW  = 3'h2,
		DOR_OPEN = 3'h3,
		DOR_XRD  = 3'h4,
		DOR_XWR  = 3'h5,
		DOR_WB   = 3'h6
	} dor_state_t;
endpackage

// File: verilog/dor_mem_if.sv
// Port between the engine and its descriptor/data memory
`timescale 1ns/100ps
interface dor_mem_if;
	logic                     en;
	logic                     we;
	logic [dor_pkg::MEM_AW-1:0] addr;
	logic [31:0]              wdata;
	logic [31:0]              rdata;
	modport master (output en, output we, output addr, output wdata,
		input rdata);
	modport mem (input en, input we, input addr, input wdata,
		output rdata);
endinterface

// File: verilog/dor_mem.sv
// Small word memory holding descriptors and transfer data
`timescale 1ns/100ps
module dor_mem (
	input  wire logic pclk,
	input  wire logic presetn,
	dor_mem_if.mem    port
);
	localparam int DEPTH = 2 ** dor_pkg::MEM_AW;

	typedef struct packed {
		logic [DEPTH-1:0][31:0] m;
		logic [31:0]            rd;
	} dor_mem_st_t;

	dor_mem_st_t r;
	dor_mem_st_t next_r;

	always_comb begin
		next_r = r;
		if (port.en && port.we) begin
			next_r.m[port.addr] = port.wdata;
		end
		if (port.en) begin
			next_r.rd = r.m[port.addr];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign port.rdata = r.rd;
endmodule

// File: verilog/dor_addr_unit.sv
// Address step and per-trigger open address for one address channel
`timescale 1ns/100ps
module dor_addr_unit (
	input  wire logic [31:0] base,
	input  wire logic [2:0]  code,
	input  wire logic [7:0]  inner_initial_count,
	input  wire logic [7:0]  inner_remaining_count,
	output logic      [31:0] step,
	output logic      [31:0] open_addr
);
	logic [7:0] done_cnt;

	always_comb begin
		case (code)
			3'h0, 3'h1: step = 32'h0000_0004;
			3'h2, 3'h3: step = 32'h0000_0008;
			3'h4:       step = 32'h0000_0010;
			3'h5:       step = 32'h0000_0000;
			default:    step = 32'hffff_fffc;
		endcase
	end

	// With inner reload the word keeps the start; the position within
	// the inner loop is rebuilt from how far the inner count has run
	assign done_cnt  = 8'(inner_initial_count - inner_remaining_count);
	assign open_addr = code[0] ? 32'(base + 32'(done_cnt) * step) : base;
endmodule

// File: verilog/dor_top.sv
// Descriptor engine with outer reload, APB registers and local memory
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/100ps
module dor_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	typedef struct packed {
		dor_pkg::dor_state_t        state;
		logic [2:0]                 idx;
		logic [6:0][31:0]           w;
		logic [31:0]                src;
		logic [31:0]                dst;
		logic [15:0]                outer_remaining_count;
		logic [7:0]                 inner_remaining_count;
		logic                       fin;
		logic                       multi;
		logic [dor_pkg::MEM_AW-1:0] descriptor_pointer;
		logic                       done;
		logic                       open_err;
		logic                       refused;
		logic                       rebuild;
		logic                       mphase;
		logic                       pready;
		logic                       pslverr;
		logic [31:0]                prdata;
	} dor_st_t;

	dor_st_t r;
	dor_st_t next_r;

	dor_mem_if mem ();

	dor_mem u_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.port    (mem.mem)
	);

	// Descriptor length from the selector bits
	function automatic logic [2:0] desc_size(input logic [2:0] outer_reload_select);
		desc_size = 3'(dor_pkg::MAND_WORDS + {2'b0, outer_reload_select[0]}
			+ {2'b0, outer_reload_select[1]} + {2'b0, outer_reload_select[2]});
	endfunction

	// Slot of backup word sel (0 count, 1 source, 2 dest); absent
	// words take no slot so later ones move down
	function automatic logic [2:0] bk_slot(input logic [2:0] outer_reload_select,
		input logic [1:0] sel);
		bk_slot = dor_pkg::W_BACKUP;
		if (sel != 2'h0) begin
			bk_slot = 3'(bk_slot + {2'b0, outer_reload_select[0]});
		end
		if (sel == 2'h2) begin
			bk_slot = 3'(bk_slot + {2'b0, outer_reload_select[1]});
		end
	endfunction

	logic [31:0] w0;
	logic [31:0] w1;
	logic [2:0]  outer_reload_select;
	logic        mode1;
	logic [2:0]  source_update_code;
	logic [2:0]  dac;
	logic [7:0]  inner_initial_count;
	logic [31:0] s_step;
	logic [31:0] d_step;
	logic [31:0] s_open;
	logic [31:0] d_open;
	logic [31:0] wb0;
	logic [31:0] wb1;
	logic [31:0] wb2;
	logic [31:0] wb3;
	logic        need;
	logic        acc;
	logic        fin_edge;
	logic        mem_hit;
	logic [7:0]  reg_off;
	logic [31:0] reg_rd;
	logic        reg_bad;

	assign w0    = r.w[dor_pkg::W_CTRL];
	assign w1    = r.w[dor_pkg::W_CNT];
	assign outer_reload_select   = w0[dor_pkg::ORL_LO +: 3];
	assign mode1 = w0[dor_pkg::MODE_B];
	assign source_update_code   = w0[dor_pkg::SAC_LO +: 3];
	assign dac   = w0[dor_pkg::DAC_LO +: 3];
	assign inner_initial_count   = w1[dor_pkg::IIN_LO +: 8];

	dor_addr_unit u_src (
		.base      (r.w[dor_pkg::W_SRC]),
		.code      (source_update_code),
		.inner_initial_count       (inner_initial_count),
		.inner_remaining_count       (w1[dor_pkg::IRM_LO +: 8]),
		.step      (s_step),
		.open_addr (s_open)
	);

	dor_addr_unit u_dst (
		.base      (r.w[dor_pkg::W_DST]),
		.code      (dac),
		.inner_initial_count       (inner_initial_count),
		.inner_remaining_count       (w1[dor_pkg::IRM_LO +: 8]),
		.step      (d_step),
		.open_addr (d_open)
	);

	// Values written back at the end of each trigger
	always_comb begin
		if (r.fin && outer_reload_select[0]) begin
			wb1 = r.w[bk_slot(outer_reload_select, 2'h0)];
		end else if (r.fin) begin
			wb1 = {dor_pkg::ORM_END, inner_initial_count, dor_pkg::IRM_END};
		end else begin
			wb1 = {r.outer_remaining_count, inner_initial_count, r.inner_remaining_count};
		end
		if (r.fin && outer_reload_select[1]) begin
			wb2 = r.w[bk_slot(outer_reload_select, 2'h1)];
		end else if (!r.fin && !source_update_code[0]) begin
			wb2 = r.src;
		end else begin
			// Final trigger opened at the last outer start or last
			// used address, so the opening value is what stays
			wb2 = r.w[dor_pkg::W_SRC];
		end
		if (r.fin && outer_reload_select[2]) begin
			wb3 = r.w[bk_slot(outer_reload_select, 2'h2)];
		end else if (!r.fin && !dac[0]) begin
			wb3 = r.dst;
		end else begin
			wb3 = r.w[dor_pkg::W_DST];
		end
		need = (!outer_reload_select[0] && (r.multi || wb1 != w1))
			|| (!outer_reload_select[1] && !source_update_code[0] && r.multi)
			|| (!outer_reload_select[2] && !dac[0] && r.multi);
		wb0 = w0;
		if (!r.fin) begin
			wb0[dor_pkg::ST_LO +: 2] = dor_pkg::ST_RUN;
		end else if (need) begin
			wb0[dor_pkg::ST_LO +: 2] = dor_pkg::ST_REBUILD;
		end else begin
			wb0[dor_pkg::ST_LO +: 2] = dor_pkg::ST_CLEAN;
		end
	end

	assign reg_off = paddr[7:0];
	assign mem_hit = paddr[dor_pkg::MEM_SEL_BIT];

	always_comb begin
		reg_bad = 1'b0;
		case (reg_off)
			dor_pkg::REG_CTRL: reg_rd = '0;
			dor_pkg::REG_DESCRIPTOR_POINTER: reg_rd = 32'({r.descriptor_pointer, 2'b00});
			dor_pkg::REG_STAT: reg_rd = {27'h0, r.rebuild, r.refused,
				r.open_err, r.done, r.state != dor_pkg::DOR_IDLE};
			default: begin
				reg_rd  = '0;
				reg_bad = 1'b1;
			end
		endcase
	end

	always_comb begin
		next_r      = r;
		mem.en      = 1'b0;
		mem.we      = 1'b0;
		mem.addr    = 5'(r.descriptor_pointer + {2'b00, r.idx});
		mem.wdata   = '0;
		acc         = psel && penable && !r.pready;
		fin_edge    = psel && penable && r.pready && pwrite;
		next_r.pready  = 1'b0;
		next_r.pslverr = 1'b0;

		// Register side answers one cycle after the access phase opens;
		// memory waits for the engine to be idle
		if (acc && !mem_hit) begin
			// Read data holds across writes until the next read answer
			next_r.pready  = 1'b1;
			next_r.prdata  = pwrite ? r.prdata : reg_rd;
			next_r.pslverr = reg_bad;
		end else if (acc && r.state == dor_pkg::DOR_IDLE) begin
			if (!pwrite && !r.mphase) begin
				mem.en        = 1'b1;
				mem.addr      = paddr[dor_pkg::MEM_AW+1:2];
				next_r.mphase = 1'b1;
			end else begin
				next_r.pready = 1'b1;
				next_r.mphase = 1'b0;
				next_r.prdata = pwrite ? r.prdata : mem.rdata;
			end
		end

		// Writes land on the completing edge; clears come before the
		// engine below so a same-cycle set wins
		if (fin_edge && mem_hit) begin
			mem.en    = 1'b1;
			mem.we    = 1'b1;
			mem.addr  = paddr[dor_pkg::MEM_AW+1:2];
			mem.wdata = pwdata;
		end else if (fin_edge) begin
			case (reg_off)
				dor_pkg::REG_CTRL: begin
					if (pwdata[dor_pkg::CTRL_TRIG]) begin
						if (r.state == dor_pkg::DOR_IDLE) begin
							next_r.state = dor_pkg::DOR_RD;
							next_r.idx   = '0;
						end else begin
							next_r.refused = 1'b1;
						end
					end
				end
				dor_pkg::REG_DESCRIPTOR_POINTER: begin
					next_r.descriptor_pointer = pwdata[dor_pkg::MEM_AW+1:2];
				end
				dor_pkg::REG_STAT: begin
					if (pwdata[dor_pkg::STAT_DONE]) next_r.done = 1'b0;
					if (pwdata[dor_pkg::STAT_OPENERR]) next_r.open_err = 1'b0;
					if (pwdata[dor_pkg::STAT_REFUSED]) next_r.refused = 1'b0;
					if (pwdata[dor_pkg::STAT_REBUILD]) next_r.rebuild = 1'b0;
				end
				default: begin
				end
			endcase
		end

		case (r.state)
			dor_pkg::DOR_IDLE: begin
			end
			dor_pkg::DOR_RD: begin
				mem.en       = 1'b1;
				next_r.state = dor_pkg::DOR_RDW;
			end
			dor_pkg::DOR_RDW: begin
				next_r.w[r.idx] = mem.rdata;
				next_r.idx      = 3'(r.idx + 3'h1);
				if (3'(r.idx + 3'h1) == desc_size((r.idx == '0) ?
					mem.rdata[dor_pkg::ORL_LO +: 3] : outer_reload_select)) begin
					next_r.state = dor_pkg::DOR_OPEN;
				end else begin
					next_r.state = dor_pkg::DOR_RD;
				end
			end
			dor_pkg::DOR_OPEN: begin
				next_r.state = dor_pkg::DOR_IDLE;
				if (w0[dor_pkg::DV_LO +: 2] == 2'b00) begin
					next_r.refused = 1'b1;
				end else if (w0[dor_pkg::DV_LO + 1] && w0[dor_pkg::ST_LO +: 2]
					== dor_pkg::ST_REBUILD) begin
					next_r.open_err = 1'b1;
				end else begin
					next_r.state = dor_pkg::DOR_XRD;
					next_r.src   = s_open;
					next_r.dst   = d_open;
					next_r.outer_remaining_count   = w1[dor_pkg::ORM_LO +: 16];
					next_r.inner_remaining_count   = mode1 ? w1[dor_pkg::IRM_LO +: 8] : inner_initial_count;
					next_r.fin   = 1'b0;
					next_r.multi = w0[dor_pkg::ST_LO +: 2] == dor_pkg::ST_RUN;
				end
			end
			dor_pkg::DOR_XRD: begin
				mem.en       = 1'b1;
				mem.addr     = r.src[dor_pkg::MEM_AW+1:2];
				next_r.state = dor_pkg::DOR_XWR;
			end
			dor_pkg::DOR_XWR: begin
				mem.en       = 1'b1;
				mem.we       = 1'b1;
				mem.addr     = r.dst[dor_pkg::MEM_AW+1:2];
				mem.wdata    = mem.rdata;
				next_r.src   = 32'(r.src + s_step);
				next_r.dst   = 32'(r.dst + d_step);
				next_r.idx   = '0;
				next_r.state = mode1 ? dor_pkg::DOR_WB : dor_pkg::DOR_XRD;
				if (r.inner_remaining_count != 8'h01) begin
					next_r.inner_remaining_count = 8'(r.inner_remaining_count - 8'h01);
				end else if (r.outer_remaining_count == dor_pkg::ORM_END) begin
					// Sequence complete: counts stay at one
					next_r.fin   = 1'b1;
					next_r.state = dor_pkg::DOR_WB;
				end else begin
					next_r.outer_remaining_count   = 16'(r.outer_remaining_count - 16'h0001);
					next_r.inner_remaining_count   = inner_initial_count;
					next_r.state = dor_pkg::DOR_WB;
					if (source_update_code[0]) next_r.src = r.w[dor_pkg::W_SRC];
					if (dac[0]) next_r.dst = r.w[dor_pkg::W_DST];
				end
			end
			dor_pkg::DOR_WB: begin
				// Only words 0..3 are written; backups are left alone
				mem.en     = 1'b1;
				mem.we     = 1'b1;
				next_r.idx = 3'(r.idx + 3'h1);
				case (r.idx)
					dor_pkg::W_CTRL: mem.wdata = wb0;
					dor_pkg::W_CNT:  mem.wdata = wb1;
					dor_pkg::W_SRC:  mem.wdata = wb2;
					default:         mem.wdata = wb3;
				endcase
				if (r.idx == dor_pkg::W_DST) begin
					next_r.state = dor_pkg::DOR_IDLE;
					next_r.done  = 1'b1;
					if (r.fin && need) next_r.rebuild = 1'b1;
				end
			end
			default: begin
				next_r.state = dor_pkg::DOR_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r       <= '0;
			r.state <= dor_pkg::DOR_IDLE;
			r.descriptor_pointer  <= dor_pkg::RST_DESCRIPTOR_POINTER;
		end else begin
			r <= next_r;
		end
	end

	assign prdata  = r.prdata;
	assign pready  = r.pready;
	assign pslverr = r.pslverr;
endmodule

// File: verif/dor_cpu_model.sv
// APB master standing in for the CPU that builds descriptors
`timescale 1ns/100ps
module dor_cpu_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end

	// Holds the request until pready; only the bench watchdog ends a hang
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released address and data lines flip so stale values never pass for live ones
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// File: verif/dor_top_properties.sv
// Concurrent checks on the APB face of the descriptor engine
`timescale 1ns/100ps
module dor_top_properties (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence reg_access;
		$rose(penable) && psel && !paddr[8];
	endsequence
	sequence mem_read;
		$rose(penable) && psel && paddr[8] && !pwrite;
	endsequence

	a_reg_answer: assert property (reg_access |=> pready)
		else $error("register access answer late");
	// Bound covers the longest transfer the bench starts
	a_mem_answer: assert property (mem_read |=> !pready ##[1:400] pready)
		else $error("memory read answer out of window");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	a_err_decode: assert property (pready && !paddr[8] |->
		pslverr == (paddr[7:0] > 8'h08 || paddr[1:0] != 2'h0))
		else $error("register decode error flag wrong");
	a_mem_no_err: assert property (pready && paddr[8] |-> !pslverr)
		else $error("memory window flagged error");
	a_err_zero: assert property (pready && pslverr && !pwrite |->
		prdata == 32'h0)
		else $error("refused read returned data");
	a_ctrl_zero: assert property (pready && !pwrite && paddr == 12'h000 |->
		prdata == 32'h0)
		else $error("control register read not zero");
	a_stat_width: assert property (pready && !pwrite && paddr == 12'h008
		|-> prdata[31:5] == 27'h0)
		else $error("status upper bits set");
	a_data_holds: assert property (!(pready && !pwrite) |-> $stable(prdata))
		else $error("read data moved without a read");
endmodule

bind dor_top dor_top_properties dor_top_properties_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr));

// File: verif/tb_top.sv
// Self-checking bench: descriptor reload scenarios over APB
`timescale 1ns/100ps
module tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	int          errors;
	int          total_checks;
	logic [31:0] q;
	logic        e;
	logic [31:0] d [7];

	initial pclk = 1'b0;
	always #25 pclk = ~pclk;

	dor_top dor_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	dor_cpu_model dor_cpu_model_inst (.pclk(pclk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		dor_cpu_model_inst.xfer(1'b1, a, v, q, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x,
		input string nm);
		dor_cpu_model_inst.xfer(1'b0, a, 32'h0, q, e);
		chk(nm, x, q);
	endtask
	function automatic logic [11:0] mw(input int i);
		return 12'h100 | 12'(i * 4);
	endfunction
	task automatic load(input int n);
		for (int i = 0; i < n; i++) wr(mw(i), d[i]);
	endtask
	// Status is cleared before each trigger, so the last read shows one run
	task automatic go(input int n, input logic [31:0] st, input logic twice);
		for (int t = 0; t < n; t++) begin
			wr(12'h008, 32'h1e);
			wr(12'h000, 32'h1);
			if (twice) wr(12'h000, 32'h1);
			do dor_cpu_model_inst.xfer(1'b0, 12'h008, 32'h0, q, e);
			while (q[0] !== 1'b0);
		end
		chk("status", st, q);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#1000000;
		errors++;
		finish_test();
	end

	initial begin
		presetn = 1'b0;
		errors = 0;
		total_checks = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h008, 32'h0, "stat reset");
		rd(12'h004, 32'h0, "descriptor_pointer reset");
		wr(12'h004, 32'hffffffff);
		rd(12'h004, 32'h7c, "descriptor_pointer bits");
		wr(12'h004, 32'h0);
		rd(12'h000, 32'h0, "ctrl read");
		rd(12'h00c, 32'h0, "unmapped data");
		chk("unmapped err", 32'h1, {31'h0, e});
		for (int i = 16; i < 20; i++) wr(mw(i), 32'hd0d00000 + 32'(i));
		// Single mode, counter and dest reloaded, source left moving
		d = '{32'hb3, 32'h00010202, 32'h40, 32'h60, 32'h00010202, 32'h60,
			32'h5a5a5a5a};
		load(7);
		go(2, 32'h12, 1'b0);
		rd(mw(0), 32'hbf, "a ctrl");
		rd(mw(1), 32'h00010202, "a count");
		rd(mw(2), 32'h44, "a source");
		rd(mw(3), 32'h60, "a dest");
		rd(mw(4), d[4], "a count backup");
		rd(mw(5), d[5], "a dest backup");
		rd(mw(6), d[6], "a past end");
		rd(mw(24), 32'hd0d00010, "a data0");
		rd(mw(25), 32'hd0d00011, "a data1");
		rd(mw(26), 32'h0, "a no extra");
		go(1, 32'h04, 1'b0);
		rd(mw(0), 32'hbf, "a ctrl kept");
		// Counter and source reloaded, dest left at last address
		d = '{32'h73, 32'h00010202, 32'h40, 32'h60, 32'h00010202, 32'h40,
			32'h5a5a5a5a};
		load(6);
		go(2, 32'h12, 1'b0);
		rd(mw(1), 32'h00010202, "c count");
		rd(mw(2), 32'h40, "c source");
		rd(mw(3), 32'h64, "c dest");
		rd(mw(5), 32'h40, "c source backup");
		rd(mw(6), 32'h5a5a5a5a, "c past end");
		// Burst mode, no reload, dest with inner reload
		d[0] = 32'h803;
		d[1] = 32'h00020202;
		d[2] = 32'h40;
		d[3] = 32'h60;
		load(4);
		go(1, 32'h0a, 1'b1);
		go(1, 32'h12, 1'b0);
		rd(mw(0), 32'h80f, "b ctrl");
		rd(mw(1), 32'h00010201, "b count");
		rd(mw(1), 32'h00010201, "b initial");
		rd(mw(2), 32'h48, "b source");
		rd(mw(3), 32'h60, "b dest");
		rd(mw(4), 32'h00010202, "b past end");
		rd(mw(24), 32'hd0d00012, "b data0");
		rd(mw(25), 32'hd0d00013, "b data1");
		// Ownership with the CPU: refused, nothing written back
		wr(mw(0), 32'h800);
		go(1, 32'h08, 1'b0);
		rd(mw(0), 32'h800, "b owner kept");
		finish_test();
	end
endmodule
